/* rtl/channel_calibration_config_regs.sv */
// Channel 0 calibration and channel 1 configuration register slice
//
// Function
// - Offset 0Ah holds offset word bits 23:8, signed, reset zero.
// - Offset 0Bh holds offset bits 7:0 in 15:8; low byte reads zero.
// - Offset 0Ch holds gain word bits 23:8, fully read and write.
// - Offset 0Dh holds gain bits 7:0 in 15:8; low byte zero; reset zero.
// - Gain word is an unsigned fraction from 0.0 to just below 2.0.
// - Upper gain register reads 8000h after reset, gain at midscale.
// - Upper offset register reads 0000h after reset.
// - Config at 0Eh resets to 0000h; bits 5:3 always read zero.
// - Config bits 15:6 are a signed phase delay in modulator cycles.
// - Config bit 2 set turns DC blocking off for channel 1.
// - Config bits 1:0 pick own pins, shorted, positive or negative test.
// - Global 4-bit DC-block setting governs channel when bit 2 clear.
`timescale 1ns/1ps
`include "cal_cfg_map.svh"
module channel_calibration_config_regs (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire cal_cfg_pkg::reg_word_t reg_wr_data,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output cal_cfg_pkg::reg_word_t     reg_rd_data_q,
    // Global DC-block setting from the neighbouring register
    input  wire logic [3:0]            global_dc_block_setting,
    // Channel 0 calibration words
    output logic [23:0]                ch0_offset_word_q,
    output logic [23:0]                ch0_gain_word_q,
    output logic                       ch0_gain_ge_one_q,
    // Channel 1 configuration
    output logic [9:0]                 ch1_phase_delay_q,
    output logic                       ch1_dc_block_off_q,
    output cal_cfg_pkg::input_select_t ch1_input_select_q,
    output logic [3:0]                 ch1_dc_block_eff_q,
    output logic [3:0]                 ch1_source_onehot_q
);
    import cal_cfg_pkg::*;

    localparam int NUM_REGS = 5;

    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        `CAL_ADDR_OFS_HIGH,
        `CAL_ADDR_OFS_LOW,
        `CAL_ADDR_GAIN_HIGH,
        `CAL_ADDR_GAIN_LOW,
        `CAL_ADDR_CH1_CHANNEL_CONFIG
    };

    localparam logic [15:0] REG_RESET [NUM_REGS] = '{
        `CAL_RST_OFS_HIGH,
        `CAL_RST_OFS_LOW,
        `CAL_RST_GAIN_HIGH,
        `CAL_RST_GAIN_LOW,
        `CAL_RST_CH1_CHANNEL_CONFIG
    };

    localparam logic [15:0] REG_MASK [NUM_REGS] = '{
        `CAL_MASK_OFS_HIGH,
        `CAL_MASK_OFS_LOW,
        `CAL_MASK_GAIN_HIGH,
        `CAL_MASK_GAIN_LOW,
        `CAL_MASK_CH1_CHANNEL_CONFIG
    };

    reg_word_t   reg_q [NUM_REGS];
    logic        wr_hit [NUM_REGS];
    reg_word_t   rd_mux;
    reg_word_t   cfg_word;

    // Register cells, one per offset
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            assign wr_hit[gi] = reg_wr && (reg_addr == REG_ADDR[gi]);
            cal_reg_cell #(
                .RESET_VAL (REG_RESET[gi]),
                .WR_MASK   (REG_MASK[gi])
            ) u_cell (
                .sys_clk (sys_clk),
                .rst     (rst),
                .wr_en   (wr_hit[gi]),
                .wr_data (reg_wr_data),
                .value_q (reg_q[gi])
            );
        end
    endgenerate

    // Read decode; unmapped offsets read zero
    always_comb begin
        rd_mux = 16'h0000;
        for (int k = 0; k < NUM_REGS; k++) begin
            if (reg_addr == REG_ADDR[k]) begin
                rd_mux = reg_q[k];
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rd_data_q <= 16'h0000;
        end else if (reg_rd) begin
            reg_rd_data_q <= rd_mux;
        end else begin
            reg_rd_data_q <= 16'h0000;
        end
    end

    // Offset word, two's complement
    assign ch0_offset_word_q = {
        reg_q[IDX_OFS_HIGH],
        reg_q[IDX_OFS_LOW][`CAL_LOW_MSB:`CAL_LOW_LSB]
    };

    // Gain word, unsigned fraction
    assign ch0_gain_word_q = {
        reg_q[IDX_GAIN_HIGH],
        reg_q[IDX_GAIN_LOW][`CAL_LOW_MSB:`CAL_LOW_LSB]
    };

    // Top gain bit weighs 1.0
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ch0_gain_ge_one_q <= 1'b1;
        end else begin
            ch0_gain_ge_one_q <= ch0_gain_word_q[23];
        end
    end

    // Channel 1 configuration fields
    assign cfg_word = reg_q[IDX_CH1_CHANNEL_CONFIG];

    assign ch1_phase_delay_q =
        cfg_word[`CAL_CFG_PHASE_MSB:`CAL_CFG_PHASE_LSB];

    assign ch1_dc_block_off_q = cfg_word[`CAL_CFG_DC_OFF_BIT];

    assign ch1_input_select_q =
        input_select_t'(cfg_word[`CAL_CFG_SEL_MSB:`CAL_CFG_SEL_LSB]);

    // Effective DC-block setting for channel 1
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ch1_dc_block_eff_q <= 4'h0;
        end else if (ch1_dc_block_off_q) begin
            ch1_dc_block_eff_q <= 4'h0;
        end else begin
            ch1_dc_block_eff_q <= global_dc_block_setting;
        end
    end

    // Input source decode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ch1_source_onehot_q <= 4'h1;
        end else begin
            unique case (ch1_input_select_q)
                SEL_OWN_PINS: begin
                    ch1_source_onehot_q <= 4'h1;
                end
                SEL_SHORTED: begin
                    ch1_source_onehot_q <= 4'h2;
                end
                SEL_TEST_POS: begin
                    ch1_source_onehot_q <= 4'h4;
                end
                SEL_TEST_NEG: begin
                    ch1_source_onehot_q <= 4'h8;
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    a_offset_high_wr: assert property (
        reg_wr && reg_addr == `CAL_ADDR_OFS_HIGH
        |=> ch0_offset_word_q[23:8] == $past(reg_wr_data)
    ) else $error("offset high write not stored");

    a_offset_low_resv: assert property (
        reg_rd && reg_addr == `CAL_ADDR_OFS_LOW
        |=> reg_rd_data_q[7:0] == 8'h00
            && reg_rd_data_q[15:8] == ch0_offset_word_q[7:0]
    ) else $error("offset low read wrong");

    a_gain_high_rw: assert property (
        reg_wr && reg_addr == `CAL_ADDR_GAIN_HIGH
        ##1 reg_rd && reg_addr == `CAL_ADDR_GAIN_HIGH
        |=> reg_rd_data_q == $past(reg_wr_data, 2)
    ) else $error("gain high read back differs");

    a_gain_low_resv: assert property (
        reg_wr && reg_addr == `CAL_ADDR_GAIN_LOW
        |=> reg_q[IDX_GAIN_LOW] == {$past(reg_wr_data[15:8]), 8'h00}
    ) else $error("gain low byte not masked");

    a_gain_unity_flag: assert property (
        ##1 ch0_gain_ge_one_q == (($past(ch0_gain_word_q))
            >= `CAL_GAIN_UNITY)
    ) else $error("gain unity flag wrong");

    a_gain_reset_mid: assert property (
        disable iff (1'b0)
        rst |=> ch0_gain_word_q == `CAL_GAIN_UNITY
    ) else $error("gain not midscale after reset");

    a_offset_reset_zero: assert property (
        disable iff (1'b0)
        rst |=> ch0_offset_word_q == 24'h000000
    ) else $error("offset not zero after reset");

    a_cfg_reset_resv: assert property (
        disable iff (1'b0)
        rst ##1 !rst [*2] |-> cfg_word[5:3] == 3'h0
            && $past(cfg_word, 1) == `CAL_RST_CH1_CHANNEL_CONFIG
    ) else $error("config reset or reserved bits wrong");

    a_phase_wr: assert property (
        reg_wr && reg_addr == `CAL_ADDR_CH1_CHANNEL_CONFIG
        |=> $signed(ch1_phase_delay_q) == $signed($past(reg_wr_data[15:6]))
    ) else $error("phase delay not stored");

    a_dc_block_follow: assert property (
        ch1_dc_block_off_q |=> ch1_dc_block_eff_q == 4'h0
    ) else $error("dc block not off");

    a_dc_global_use: assert property (
        !ch1_dc_block_off_q
        |=> ch1_dc_block_eff_q == $past(global_dc_block_setting)
    ) else $error("global dc setting not followed");

    a_select_decode: assert property (
        ##1 ch1_source_onehot_q
            == (4'h1 << $past(ch1_input_select_q))
    ) else $error("input select decode wrong");

    a_resv_ignored: assert property (
        reg_wr && reg_addr == `CAL_ADDR_CH1_CHANNEL_CONFIG
        |=> cfg_word[5:3] == 3'h0
    ) else $error("reserved config bits took a write");

    a_read_single: assert property (
        !reg_rd |=> reg_rd_data_q == 16'h0000
    ) else $error("read data outside read cycle");

    a_offset_low_wr: assert property (
        reg_wr && reg_addr == `CAL_ADDR_OFS_LOW
        |=> ch0_offset_word_q[7:0] == $past(reg_wr_data[15:8])
    ) else $error("offset low write not stored");

    a_gain_high_wr: assert property (
        reg_wr && reg_addr == `CAL_ADDR_GAIN_HIGH
        |=> ch0_gain_word_q[23:8] == $past(reg_wr_data)
    ) else $error("gain high write not stored");

    a_gain_low_wr: assert property (
        reg_wr && reg_addr == `CAL_ADDR_GAIN_LOW
        |=> ch0_gain_word_q[7:0] == $past(reg_wr_data[15:8])
    ) else $error("gain low write not stored");

    a_offset_high_rd: assert property (
        reg_rd && reg_addr == `CAL_ADDR_OFS_HIGH
        |=> reg_rd_data_q == ch0_offset_word_q[23:8]
    ) else $error("offset high read wrong");

    a_gain_high_rd: assert property (
        reg_rd && reg_addr == `CAL_ADDR_GAIN_HIGH
        |=> reg_rd_data_q == ch0_gain_word_q[23:8]
    ) else $error("gain high read wrong");

    a_gain_low_rd: assert property (
        reg_rd && reg_addr == `CAL_ADDR_GAIN_LOW
        |=> reg_rd_data_q == {ch0_gain_word_q[7:0], 8'h00}
    ) else $error("gain low read wrong");

    a_cfg_read: assert property (
        reg_rd && reg_addr == `CAL_ADDR_CH1_CHANNEL_CONFIG
        |=> reg_rd_data_q == {ch1_phase_delay_q, 3'h0,
            ch1_dc_block_off_q, ch1_input_select_q}
    ) else $error("config read wrong");

    a_dc_off_wr: assert property (
        reg_wr && reg_addr == `CAL_ADDR_CH1_CHANNEL_CONFIG
        |=> ch1_dc_block_off_q == $past(reg_wr_data[2])
    ) else $error("dc block off bit not stored");

    a_select_wr: assert property (
        reg_wr && reg_addr == `CAL_ADDR_CH1_CHANNEL_CONFIG
        |=> ch1_input_select_q == $past(reg_wr_data[1:0])
    ) else $error("input select not stored");

    a_unmapped_read: assert property (
        reg_rd && (reg_addr < `CAL_ADDR_OFS_HIGH
            || reg_addr > `CAL_ADDR_CH1_CHANNEL_CONFIG)
        |=> reg_rd_data_q == 16'h0000
    ) else $error("unmapped read not zero");

    a_flag_reset_one: assert property (
        disable iff (1'b0)
        rst |=> ch0_gain_ge_one_q
    ) else $error("gain flag not set after reset");

    a_derived_reset: assert property (
        disable iff (1'b0)
        rst |=> ch1_dc_block_eff_q == 4'h0 && ch1_source_onehot_q == 4'h1
    ) else $error("derived outputs wrong after reset");

    a_words_hold: assert property (
        !reg_wr |=> $stable(ch0_offset_word_q) && $stable(ch0_gain_word_q)
            && $stable(cfg_word)
    ) else $error("register changed without write");

    a_offset_low_mask: assert property (
        reg_wr && reg_addr == `CAL_ADDR_OFS_LOW
        |=> reg_q[IDX_OFS_LOW][7:0] == 8'h00
    ) else $error("offset low reserved byte took a write");

    c_gain_write: cover property (
        reg_wr && reg_addr == `CAL_ADDR_GAIN_LOW
    );

    c_dc_off: cover property (
        $rose(ch1_dc_block_off_q)
    );

    c_test_neg: cover property (
        ch1_input_select_q == SEL_TEST_NEG
        ##1 ch1_source_onehot_q == 4'h8
    );

    c_read_after_write: cover property (
        reg_wr ##1 reg_rd
    );

    c_unmapped_read: cover property (
        reg_rd && reg_addr == 8'h0f
    );

endmodule

/* rtl/cal_cfg_map.svh */
// Offsets, field positions, reset values and write masks of the register slice
`ifndef CAL_CFG_MAP_SVH
`define CAL_CFG_MAP_SVH

// Register offsets
`define CAL_ADDR_OFS_HIGH   8'h0a
`define CAL_ADDR_OFS_LOW    8'h0b
`define CAL_ADDR_GAIN_HIGH  8'h0c
`define CAL_ADDR_GAIN_LOW   8'h0d
`define CAL_ADDR_CH1_CHANNEL_CONFIG    8'h0e

// Reset values
`define CAL_RST_OFS_HIGH    16'h0000
`define CAL_RST_OFS_LOW     16'h0000
`define CAL_RST_GAIN_HIGH   16'h8000
`define CAL_RST_GAIN_LOW    16'h0000
`define CAL_RST_CH1_CHANNEL_CONFIG     16'h0000

// Writable bits; clear bits are reserved and read zero
`define CAL_MASK_OFS_HIGH   16'hffff
`define CAL_MASK_OFS_LOW    16'hff00
`define CAL_MASK_GAIN_HIGH  16'hffff
`define CAL_MASK_GAIN_LOW   16'hff00
`define CAL_MASK_CH1_CHANNEL_CONFIG    16'hffc7

// Channel 1 configuration fields
`define CAL_CFG_PHASE_MSB   15
`define CAL_CFG_PHASE_LSB   6
`define CAL_CFG_RESV_MSB    5
`define CAL_CFG_RESV_LSB    3
`define CAL_CFG_DC_OFF_BIT  2
`define CAL_CFG_SEL_MSB     1
`define CAL_CFG_SEL_LSB     0

// Low registers carry word bits 7:0 in their upper byte
`define CAL_LOW_MSB         15
`define CAL_LOW_LSB         8

// Gain midscale, 1.0 in the 0.0 to 2.0 range
`define CAL_GAIN_UNITY      24'h800000

`endif

/* rtl/cal_cfg_pkg.sv */
// Types shared by the calibration and configuration register slice
package cal_cfg_pkg;

    typedef enum logic [1:0] {
        SEL_OWN_PINS = 2'b00,
        SEL_SHORTED  = 2'b01,
        SEL_TEST_POS = 2'b10,
        SEL_TEST_NEG = 2'b11
    } input_select_t;

    typedef enum logic [2:0] {
        IDX_OFS_HIGH  = 3'h0,
        IDX_OFS_LOW   = 3'h1,
        IDX_GAIN_HIGH = 3'h2,
        IDX_GAIN_LOW  = 3'h3,
        IDX_CH1_CHANNEL_CONFIG   = 3'h4
    } reg_index_t;

    typedef logic [15:0] reg_word_t;

endpackage

/* rtl/cal_reg_cell.sv */
// One 16-bit software register with reset value and writable-bit mask
`timescale 1ns/1ps
module cal_reg_cell #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK   = 16'hffff
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Write side
    input  wire logic                  wr_en,
    input  wire cal_cfg_pkg::reg_word_t wr_data,
    // Stored value
    output cal_cfg_pkg::reg_word_t     value_q
);
    import cal_cfg_pkg::*;

    // Masked bits never load, so reserved bits stay zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            value_q <= RESET_VAL & WR_MASK;
        end else if (wr_en) begin
            value_q <= wr_data & WR_MASK;
        end
    end

endmodule

/* verification/testbench.sv */
// Self-checking bench for the calibration and configuration slice
`timescale 1ns/1ps
`include "cal_cfg_map.svh"
module testbench;
    import cal_cfg_pkg::*;

    logic          sys_clk;
    logic          rst;
    logic [7:0]    reg_addr;
    reg_word_t     reg_wr_data;
    logic          reg_wr;
    logic          reg_rd;
    reg_word_t     reg_rd_data_q;
    logic [3:0]    global_dc_block_setting;
    logic [23:0]   ch0_offset_word_q;
    logic [23:0]   ch0_gain_word_q;
    logic          ch0_gain_ge_one_q;
    logic [9:0]    ch1_phase_delay_q;
    logic          ch1_dc_block_off_q;
    input_select_t ch1_input_select_q;
    logic [3:0]    ch1_dc_block_eff_q;
    logic [3:0]    ch1_source_onehot_q;
    int            mismatches;
    int            total_checks;

    channel_calibration_config_regs i_channel_calibration_config_regs (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .reg_addr                (reg_addr),
        .reg_wr_data             (reg_wr_data),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_rd_data_q           (reg_rd_data_q),
        .global_dc_block_setting (global_dc_block_setting),
        .ch0_offset_word_q       (ch0_offset_word_q),
        .ch0_gain_word_q         (ch0_gain_word_q),
        .ch0_gain_ge_one_q       (ch0_gain_ge_one_q),
        .ch1_phase_delay_q       (ch1_phase_delay_q),
        .ch1_dc_block_off_q      (ch1_dc_block_off_q),
        .ch1_input_select_q      (ch1_input_select_q),
        .ch1_dc_block_eff_q      (ch1_dc_block_eff_q),
        .ch1_source_onehot_q     (ch1_source_onehot_q)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [23:0] e,
                       input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input reg_word_t d);
        @(posedge sys_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr      <= 1'b1;
        @(posedge sys_clk);
        reg_wr      <= 1'b0;
    endtask

    // Read data stands one cycle, then returns to zero
    task automatic rd_chk(input logic [7:0] a, input reg_word_t e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, reg_rd_data_q);
        @(posedge sys_clk);
        #1;
        chk("read idle", 24'h0, reg_rd_data_q);
    endtask

    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset();
        rd_chk(`CAL_ADDR_OFS_HIGH, 16'h0000);
        rd_chk(`CAL_ADDR_OFS_LOW, 16'h0000);
        rd_chk(`CAL_ADDR_GAIN_HIGH, 16'h8000);
        rd_chk(`CAL_ADDR_GAIN_LOW, 16'h0000);
        rd_chk(`CAL_ADDR_CH1_CHANNEL_CONFIG, 16'h0000);
        chk("gain word", 24'h800000, ch0_gain_word_q);
        chk("gain ge one", 24'h1, ch0_gain_ge_one_q);
        chk("offset word", 24'h0, ch0_offset_word_q);
        chk("onehot", 24'h1, ch1_source_onehot_q);
        chk("dc eff", 24'ha, ch1_dc_block_eff_q);
    endtask

    task automatic t_reserved();
        wr(`CAL_ADDR_OFS_HIGH, 16'hffff);
        wr(`CAL_ADDR_OFS_LOW, 16'hffff);
        wr(`CAL_ADDR_GAIN_HIGH, 16'hffff);
        wr(`CAL_ADDR_GAIN_LOW, 16'hffff);
        wr(`CAL_ADDR_CH1_CHANNEL_CONFIG, 16'hffff);
        settle();
        rd_chk(`CAL_ADDR_OFS_HIGH, 16'hffff);
        rd_chk(`CAL_ADDR_OFS_LOW, 16'hff00);
        rd_chk(`CAL_ADDR_GAIN_HIGH, 16'hffff);
        rd_chk(`CAL_ADDR_GAIN_LOW, 16'hff00);
        rd_chk(`CAL_ADDR_CH1_CHANNEL_CONFIG, 16'hffc7);
        chk("offset word", 24'hffffff, ch0_offset_word_q);
        chk("gain word", 24'hffffff, ch0_gain_word_q);
        chk("phase", 24'h3ff, ch1_phase_delay_q);
        chk("dc off", 24'h1, ch1_dc_block_off_q);
        chk("dc eff", 24'h0, ch1_dc_block_eff_q);
        chk("onehot", 24'h8, ch1_source_onehot_q);
    endtask

    task automatic t_words();
        wr(`CAL_ADDR_GAIN_HIGH, 16'h7fff);
        wr(`CAL_ADDR_GAIN_LOW, 16'hab34);
        wr(`CAL_ADDR_OFS_HIGH, 16'h8001);
        wr(`CAL_ADDR_OFS_LOW, 16'h5a12);
        settle();
        chk("gain word", 24'h7fffab, ch0_gain_word_q);
        chk("gain ge one", 24'h0, ch0_gain_ge_one_q);
        chk("offset word", 24'h80015a, ch0_offset_word_q);
        wr(`CAL_ADDR_GAIN_HIGH, 16'h8000);
        settle();
        chk("gain ge one", 24'h1, ch0_gain_ge_one_q);
    endtask

    task automatic t_config();
        for (int s = 0; s < 4; s++) begin
            wr(`CAL_ADDR_CH1_CHANNEL_CONFIG, {10'h201, 3'b111, 1'b0, s[1:0]});
            settle();
            rd_chk(`CAL_ADDR_CH1_CHANNEL_CONFIG,
                   {10'h201, 3'b000, 1'b0, s[1:0]});
            chk("select", 24'(s), ch1_input_select_q);
            chk("onehot", 24'h1 << s, ch1_source_onehot_q);
            chk("phase", 24'h201, ch1_phase_delay_q);
            chk("dc eff", 24'ha, ch1_dc_block_eff_q);
        end
        @(posedge sys_clk);
        global_dc_block_setting <= 4'h5;
        settle();
        settle();
        chk("dc eff", 24'h5, ch1_dc_block_eff_q);
    endtask

    task automatic t_unmapped();
        wr(8'h0f, 16'hffff);
        wr(8'h09, 16'hffff);
        rd_chk(8'h0f, 16'h0000);
        rd_chk(8'h00, 16'h0000);
        rd_chk(`CAL_ADDR_OFS_HIGH, 16'h8001);
        rd_chk(`CAL_ADDR_CH1_CHANNEL_CONFIG, 16'h8043);
    endtask

    // Write and read of one register with no idle cycle between
    task automatic t_back_to_back();
        @(posedge sys_clk);
        reg_addr    <= `CAL_ADDR_GAIN_HIGH;
        reg_wr_data <= 16'h1234;
        reg_wr      <= 1'b1;
        @(posedge sys_clk);
        reg_wr      <= 1'b0;
        reg_rd      <= 1'b1;
        @(posedge sys_clk);
        reg_rd      <= 1'b0;
        #1;
        chk("read after write", 24'h1234, reg_rd_data_q);
        chk("gain word", 24'h1234ab, ch0_gain_word_q);
        @(posedge sys_clk);
        #1;
        chk("read idle", 24'h0, reg_rd_data_q);
    endtask

    initial begin
        mismatches              = 0;
        total_checks            = 0;
        rst                     = 1'b1;
        reg_addr                = 8'h00;
        reg_wr_data             = 16'h0000;
        reg_wr                  = 1'b0;
        reg_rd                  = 1'b0;
        global_dc_block_setting = 4'ha;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_reserved();
        t_words();
        t_config();
        t_unmapped();
        t_back_to_back();
        summarize();
    end

    initial begin
        #40000;
        mismatches++;
        summarize();
    end
endmodule
